/* rtl/stmh_cfg.svh */
// Constants of the task management message handler.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef STMH_CFG_SVH
`define STMH_CFG_SVH
`define STMH_MSG_ABORT_TASK 8'h0D
`define STMH_MSG_ABORT_SET 8'h06
`define STMH_MSG_CLEAR_ACA 8'h16
`define STMH_MSG_CLEAR_SET 8'h0E
`define STMH_MSG_LU_RESET 8'h17
`define STMH_MSG_TGT_RESET 8'h0C
`define STMH_MSG_REJECT 8'h07
`define STMH_NUM_ACT 6
`endif

/* rtl/stmh_decode.sv */
// Message code decoder of the task management handler.
// Assumes a message with a valid context; pure combinational logic.
`timescale 1ns/1ps
`default_nettype none
`include "stmh_cfg.svh"
module stmh_decode
    import stmh_pkg::*;
#(
    parameter bit TAGGED = 1'b1,
    parameter bit HAS_CLR_ACA = 1'b1,
    parameter bit HAS_LU_RESET = 1'b1
) (
    input wire stmh_msg_t msg,
    input wire logic iu_en,
    output var stmh_verdict_t verdict,
    output var stmh_act_t act
);
    logic known;
    logic needs_clear;
    logic na_iu;
    logic it_only;

    assign it_only = (msg.nexus == STMH_NEX_IT);

    always_comb begin
        act = '0;
        known = 1'b1;
        needs_clear = 1'b1;
        na_iu = 1'b0;
        unique case (msg.code)
            `STMH_MSG_ABORT_TASK: begin
                known = TAGGED || iu_en;
                act.abort_task = !it_only &&
                    !(msg.reconnect && msg.want_q &&
                    msg.nexus != STMH_NEX_ITLQ);
            end
            `STMH_MSG_ABORT_SET: begin
                na_iu = 1'b1;
                act.abort_set = !it_only;
            end
            `STMH_MSG_CLEAR_SET: begin
                known = TAGGED;
                na_iu = 1'b1;
                act.clear_set = !it_only;
            end
            `STMH_MSG_CLEAR_ACA: begin
                known = HAS_CLR_ACA && msg.initial_conn;
                needs_clear = 1'b0;
                na_iu = 1'b1;
                act.clear_aca = !it_only;
            end
            `STMH_MSG_LU_RESET: begin
                known = HAS_LU_RESET;
                na_iu = 1'b1;
                act.lu_reset = !it_only;
            end
            `STMH_MSG_TGT_RESET: begin
                act.tgt_reset = 1'b1;
            end
            default: begin
                known = 1'b0;
            end
        endcase
        if (!known || (na_iu && iu_en)) begin
            act = '0;
        end
    end

    always_comb begin
        if (needs_clear && known && msg.atn_at_ack) begin
            verdict = STMH_V_FREE;
        end else if (!known || (na_iu && iu_en)) begin
            verdict = STMH_V_REJECT;
        end else if (act != '0) begin
            verdict = STMH_V_ACT;
        end else begin
            verdict = STMH_V_FREE;
        end
    end
endmodule
`default_nettype wire

/* rtl/stmh_handler.sv */
// Target-side handler for task management messages in MESSAGE OUT.
// Assumes a phase sequencer that runs REQ/ACK and reports each byte.
`timescale 1ns/1ps
`default_nettype none
`include "stmh_cfg.svh"
module stmh_handler
    import stmh_pkg::*;
#(
    parameter bit TAGGED = 1'b1,
    parameter bit HAS_CLR_ACA = 1'b1,
    parameter bit HAS_LU_RESET = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic atn,
    input wire logic phase_idle,
    input wire logic iu_en,
    input wire logic msg_valid,
    input wire stmh_msg_t msg,
    input wire logic rej_ready,
    output logic msg_out_req,
    output var stmh_act_t act_r,
    output logic aca_clear_r,
    output logic bus_free_req_r,
    output logic msg_in_req_r,
    output logic [7:0] msg_in_byte_r,
    output logic resume_r,
    output logic busy
);
    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        STMH_S_IDLE = 4'b0001,
        STMH_S_ACT = 4'b0010,
        STMH_S_FREE = 4'b0100,
        STMH_S_REJ = 4'b1000
    } stmh_state_t;

    stmh_state_t state_r;
    stmh_state_t state_nxt;
    stmh_verdict_t verdict;
    stmh_act_t act_dec;

    stmh_decode #(
        .TAGGED(TAGGED),
        .HAS_CLR_ACA(HAS_CLR_ACA),
        .HAS_LU_RESET(HAS_LU_RESET)
    ) u_decode (
        .msg(msg),
        .iu_en(iu_en),
        .verdict(verdict),
        .act(act_dec)
    );

    // Attention while no other phase is running and the handler is idle asks for MESSAGE OUT.
    assign msg_out_req = atn && phase_idle && state_r == STMH_S_IDLE;
    assign busy = (state_r != STMH_S_IDLE);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            STMH_S_IDLE: begin
                if (msg_valid) begin
                    unique case (verdict)
                        STMH_V_ACT: state_nxt = STMH_S_ACT;
                        STMH_V_REJECT: state_nxt = STMH_S_REJ;
                        default: state_nxt = STMH_S_FREE;
                    endcase
                end
            end
            STMH_S_ACT: state_nxt = STMH_S_FREE;
            STMH_S_FREE: state_nxt = STMH_S_IDLE;
            STMH_S_REJ: begin
                if (rej_ready) begin
                    state_nxt = STMH_S_IDLE;
                end
            end
            default: state_nxt = STMH_S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= STMH_S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Action pulses
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            act_r <= '0;
            aca_clear_r <= 1'b0;
        end else if (state_nxt == STMH_S_ACT) begin
            act_r <= act_dec;
            aca_clear_r <= act_dec.clear_aca;
        end else begin
            act_r <= '0;
            aca_clear_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Bus requests
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_free_req_r <= 1'b0;
        end else begin
            bus_free_req_r <= (state_nxt == STMH_S_FREE);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            msg_in_req_r <= 1'b0;
            msg_in_byte_r <= 8'h00;
            resume_r <= 1'b0;
        end else begin
            msg_in_req_r <= (state_nxt == STMH_S_REJ);
            msg_in_byte_r <= `STMH_MSG_REJECT;
            resume_r <= state_r == STMH_S_REJ && rej_ready;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_act_before_free: assert property (@(posedge core_clk)
        disable iff (!rst_b) (act_r != '0) |=> bus_free_req_r)
        else $error("action pulse not followed by bus free");
    chk_act_one_cycle: assert property (@(posedge core_clk)
        disable iff (!rst_b) (act_r != '0) |=> (act_r == '0))
        else $error("action pulse longer than one cycle");
    chk_iu_reject: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (state_r == STMH_S_IDLE && msg_valid && iu_en &&
        !msg.atn_at_ack && msg.code == `STMH_MSG_CLEAR_SET)
        |=> msg_in_req_r && act_r == '0)
        else $error("clear set not rejected with IU enabled");
    chk_it_abort_free: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (state_r == STMH_S_IDLE && msg_valid && !msg.atn_at_ack &&
        msg.code == `STMH_MSG_ABORT_TASK && msg.nexus == STMH_NEX_IT)
        |=> bus_free_req_r && act_r == '0 && !msg_in_req_r)
        else $error("I_T abort task not plain bus free");
    chk_tgt_reset: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (state_r == STMH_S_IDLE && msg_valid && !msg.atn_at_ack &&
        msg.code == `STMH_MSG_TGT_RESET)
        |=> act_r.tgt_reset ##1 bus_free_req_r)
        else $error("target reset sequence wrong");
    chk_atn_held_free: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (state_r == STMH_S_IDLE && msg_valid && msg.atn_at_ack &&
        msg.code == `STMH_MSG_ABORT_SET)
        |=> bus_free_req_r && act_r == '0)
        else $error("held attention did not free bus");
    chk_late_aca_rej: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (state_r == STMH_S_IDLE && msg_valid && !msg.initial_conn &&
        msg.code == `STMH_MSG_CLEAR_ACA)
        |=> msg_in_req_r && !aca_clear_r)
        else $error("late clear allegiance not rejected");
    chk_unknown_rej: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (state_r == STMH_S_IDLE && msg_valid && msg.code == 8'h55)
        |=> msg_in_req_r && msg_in_byte_r == `STMH_MSG_REJECT &&
        !bus_free_req_r)
        else $error("unknown code not rejected");
    chk_lu_event: assert property (@(posedge core_clk)
        disable iff (!rst_b)
        (state_r == STMH_S_IDLE && msg_valid && !iu_en &&
        !msg.atn_at_ack && msg.code == `STMH_MSG_LU_RESET &&
        msg.nexus != STMH_NEX_IT && HAS_LU_RESET)
        |=> act_r.lu_reset)
        else $error("unit reset event missing");
endmodule
`default_nettype wire

/* rtl/stmh_pkg.sv */
// Types shared by the task management message handler files.
// Assumes stmh_cfg.svh is on the include path.
`include "stmh_cfg.svh"
package stmh_pkg;
    // Nexus as known when the message arrives.
    typedef enum logic [1:0] {
        STMH_NEX_IT = 2'h0,
        STMH_NEX_ITL = 2'h1,
        STMH_NEX_ITLQ = 2'h2
    } stmh_nexus_t;

    // One received MESSAGE OUT byte and its context.
    typedef struct packed {
        logic [7:0] code;
        logic atn_at_ack;
        logic [1:0] nexus;
        logic reconnect;
        logic want_q;
        logic initial_conn;
    } stmh_msg_t;

    // One-cycle management action pulses toward the task manager.
    typedef struct packed {
        logic abort_task;
        logic abort_set;
        logic clear_set;
        logic clear_aca;
        logic lu_reset;
        logic tgt_reset;
    } stmh_act_t;

    // Decoder verdict.
    typedef enum logic [2:0] {
        STMH_V_FREE = 3'h1,
        STMH_V_REJECT = 3'h2,
        STMH_V_ACT = 3'h4
    } stmh_verdict_t;
endpackage

/* testbench/scsi_task_mgmt_msg_handler_tb_top.sv */
// Self-checking bench of the task management message handler.
// Assumes the handler top, its package and the initiator model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
$display("CHECK FAILED at %0t: got %0h want %0h", $time, a, e); end end
module scsi_task_mgmt_msg_handler_tb_top
    import stmh_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic phase_idle = 1'b0;
    logic iu_en = 1'b0;
    logic atn, msg_valid, rej_ready, msg_out_req, aca_clear_r;
    logic bus_free_req_r, msg_in_req_r, resume_r, busy;
    logic [7:0] msg_in_byte_r;
    stmh_msg_t msg;
    stmh_act_t act_r;
    int num_errors = 0;
    int checks = 0;
    logic [7:0] seed = 8'h2B;
    logic [7:0] pseed = 8'h2B;
    logic [7:0] tbl [7] = '{8'h0D, 8'h06, 8'h16, 8'h0E, 8'h17, 8'h0C, 8'h55};

    stmh_handler i_dut (.core_clk(core_clk), .rst_b(rst_b), .atn(atn),
        .phase_idle(phase_idle), .iu_en(iu_en), .msg_valid(msg_valid),
        .msg(msg), .rej_ready(rej_ready), .msg_out_req(msg_out_req),
        .act_r(act_r), .aca_clear_r(aca_clear_r),
        .bus_free_req_r(bus_free_req_r), .msg_in_req_r(msg_in_req_r),
        .msg_in_byte_r(msg_in_byte_r), .resume_r(resume_r), .busy(busy));

    stmh_init_model i_init (.core_clk(core_clk), .msg_out_req(msg_out_req),
        .msg_in_req(msg_in_req_r), .atn(atn), .msg_valid(msg_valid),
        .msg(msg), .rej_ready(rej_ready));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction

    // Verdict: 0 bus free only, 1 action then bus free, 2 reject.
    function automatic int expect_v(input logic [7:0] c, input logic [1:0] nx,
            input logic [2:0] ctx, input logic hold, input logic iu,
            output logic [5:0] ea);
        logic known;
        known = c inside {8'h0D, 8'h06, 8'h16, 8'h0E, 8'h17, 8'h0C};
        ea = 6'h00;
        if (known && c != 8'h16 && hold) return 0;
        if (!known || (iu && c inside {8'h06, 8'h16, 8'h0E, 8'h17})) return 2;
        if (c == 8'h16 && !ctx[0]) return 2;
        if (nx == 2'h0 && c != 8'h0C) return 0;
        if (c == 8'h0D && ctx[2] && ctx[1] && nx != 2'h2) return 0;
        case (c)
            8'h0D: ea = 6'h20;
            8'h06: ea = 6'h10;
            8'h0E: ea = 6'h08;
            8'h16: ea = 6'h04;
            8'h17: ea = 6'h02;
            default: ea = 6'h01;
        endcase
        return 1;
    endfunction

    task automatic conclude();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic run(input logic [7:0] c, input logic [1:0] nx,
            input logic [2:0] ctx, input logic hold, input logic iu);
        logic [5:0] ea;
        int v;
        int n;
        bit ok;
        v = expect_v(c, nx, ctx, hold, iu, ea);
        iu_en <= iu;
        i_init.rej_wait = int'(seed[2:0]);
        i_init.send({c, hold, nx, ctx}, ok);
        if (!ok) begin
            num_errors++;
            conclude();
        end
        #1;
        `CHK(act_r, ea)
        `CHK(aca_clear_r, ea[2])
        `CHK(bus_free_req_r, v == 0)
        `CHK(msg_in_req_r, v == 2)
        if (v != 0) `CHK(busy, 1'b1)
        if (v == 2) begin
            `CHK(msg_in_byte_r, 8'h07)
            n = 0;
            do begin
                @(posedge core_clk);
                #1;
                n++;
            end while (resume_r !== 1'b1 && n < 40);
            `CHK(resume_r, 1'b1)
            `CHK(msg_in_req_r, 1'b0)
            if (resume_r !== 1'b1) conclude();
        end
        if (v == 1) begin
            @(posedge core_clk);
            #1;
            `CHK(act_r, 6'h00)
            `CHK(bus_free_req_r, 1'b1)
        end
        repeat (2) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        pseed <= lfsr(pseed);
        phase_idle <= pseed[0] | pseed[1];
    end

    always @(negedge core_clk) begin
        if (rst_b === 1'b1) `CHK(msg_out_req, atn & phase_idle & ~busy)
    end

    initial begin
        logic [7:0] c;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 91; i++) begin
            seed = lfsr(seed);
            c = tbl[i % 7];
            if (i < 7)
                run(c, 2'h1, 3'b001, 1'b0, 1'b0);
            else if (i < 14)
                run(c, 2'h2, 3'b101, 1'b0, 1'b1);
            else if (i < 21)
                run(c, 2'h1, 3'b001, 1'b1, 1'b0);
            else
                run(c, (seed[1:0] == 2'h3) ? 2'h1 : seed[1:0],
                    {seed[2], seed[3], seed[4] | seed[5]},
                    seed[5] & seed[6] & seed[7], seed[7] & seed[3]);
        end
        conclude();
    end
endmodule
`default_nettype wire

/* testbench/stmh_init_model.sv */
// Initiator model: sends one management byte per request, ends rejects.
// Assumes the bench calls send from one process at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module stmh_init_model
    import stmh_pkg::*;
(
    input wire logic core_clk,
    input wire logic msg_out_req,
    input wire logic msg_in_req,
    output logic atn,
    output logic msg_valid,
    output var stmh_msg_t msg,
    output logic rej_ready
);
    int rej_wait = 0;
    int cnt = 0;

    initial begin
        atn = 1'b0;
        msg_valid = 1'b0;
        msg = '0;
        rej_ready = 1'b0;
    end

    task automatic send(input stmh_msg_t m, output bit ok);
        int n;
        n = 0;
        atn <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (msg_out_req !== 1'b1 && n < 40);
        ok = (msg_out_req === 1'b1);
        if (!ok) return;
        msg_valid <= 1'b1;
        msg <= m;
        atn <= m.atn_at_ack;
        @(posedge core_clk);
        msg_valid <= 1'b0;
        // A released bus no longer shows the last byte.
        msg <= ~m;
        atn <= 1'b0;
    endtask

    // Finishes MESSAGE IN after a prompt or slow delay.
    always @(posedge core_clk) begin
        rej_ready <= 1'b0;
        if (msg_in_req === 1'b1 && rej_ready !== 1'b1) begin
            if (cnt >= rej_wait) begin
                rej_ready <= 1'b1;
                cnt <= 0;
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire
